// ---- rtl/tpc_ctrl.sv ----
// Tare and demand print control with classic Wishbone register slave
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "tpc_consts.svh"

// Notes on behaviour
// - Sign correction off: tare kept, net signed
// - Sign correction on: swap so net nonnegative
// - Correction applies to every tare source
// - Correction on marks recalled tare as memory
// - Armed auto tare over threshold stores tare
// - Re-arm below reset, at once without check
// - With check, re-arm needs below and stable
// - Motion: wait up to three seconds for stability
// - Manual clear in net mode ignores motion
// - Auto clear on low weight or print
// - No check: clear on above-then-below crossing
// - With check: crossing then wait for stable
// - Clear after print once data sent
// - Zero with clear: clear tare, then zero
// - Printing indication lasts three seconds
// - No demand port: print fails with error
// - Interlock: need above threshold, one per cycle
// - Interlock block raises not-ready error
// - Auto print above minimum when stable, once
// - Repeat resends last output, duplicate marked
// - Three custom triggers, no counting
module tpc_ctrl import tpc_pkg::*; #(
	parameter int WEIGHT_W = 24,
	parameter int WAIT_CYCLES = (`TPC_WAIT_MS * (`TPC_TICK_NS / `TPC_CLK_NS)),
	parameter int PRINT_CYCLES = (`TPC_PRINT_MS * (`TPC_TICK_NS / `TPC_CLK_NS))
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sample_i,
	input wire logic signed [WEIGHT_W-1:0] gross_i,
	input wire logic no_motion_i,
	input wire logic print_done_i,
	output logic signed [WEIGHT_W-1:0] gross_o,
	output logic signed [WEIGHT_W-1:0] tare_o,
	output logic signed [WEIGHT_W-1:0] net_o,
	output logic net_mode_o,
	output logic tare_mem_label_o,
	output logic zero_cmd_o,
	output tpc_print_t print_o,
	output logic report_o,
	output logic printing_o,
	output tpc_err_t err_o
);
	localparam int CNT_W = 32;
	typedef logic signed [WEIGHT_W-1:0] tpc_w_t;

	logic [31:0] cfg_reg;
	tpc_w_t at_th_reg, at_rst_reg, cl_th_reg, pi_th_reg, pi_rst_reg, ap_th_reg, ap_rst_reg;
	tpc_w_t tare_reg, gross_reg, tare_sel, gross_sel;
	logic net_mode_reg;
	logic at_armed_reg, at_wait_reg, at_low_reg;
	logic [CNT_W-1:0] at_cnt_reg;
	logic cl_above_reg, cl_pend_reg;
	logic pi_ok_reg, pi_done_reg, ap_armed_reg;
	logic [CNT_W-1:0] pr_cnt_reg;
	logic sent_reg, zero_pend_reg;
	tpc_err_t err_set;
	logic bus_req, bus_wr;
	logic [6:0] cmd;
	logic do_clear_cmd, do_zero, do_print, do_repeat, do_report;
	logic [2:0] do_cust;
	logic print_ok, pi_block, start_demand, auto_print, at_fire;
	logic auto_clr, clr_any;
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = bus_req && wb_we_i;
	assign cmd = (bus_wr && wb_adr_i == `TPC_ADDR_CMD && wb_sel_i[0]) ? wb_dat_i[6:0] : 7'h00;
	assign do_clear_cmd = cmd[`TPC_CMD_CLEAR];
	assign do_zero = cmd[`TPC_CMD_ZERO];
	assign do_print = cmd[`TPC_CMD_PRINT];
	assign do_repeat = cmd[`TPC_CMD_REPEAT];
	assign do_cust = cmd[`TPC_CMD_CUST0 +: 3];
	assign do_report = bus_wr && wb_adr_i == `TPC_ADDR_CMD && wb_sel_i[0] && wb_dat_i[`TPC_CMD_REPORT];
	// One-cycle ack; master must drop stb before the next access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg <= `TPC_CFG_RST;
			at_th_reg <= '0;
			at_rst_reg <= '0;
			cl_th_reg <= '0;
			pi_th_reg <= '0;
			pi_rst_reg <= '0;
			ap_th_reg <= '0;
			ap_rst_reg <= '0;
		end else if (bus_wr && &wb_sel_i) begin
			unique case (wb_adr_i)
				`TPC_ADDR_CFG: cfg_reg <= wb_dat_i;
				`TPC_ADDR_TATH: at_th_reg <= tpc_w_t'(wb_dat_i[WEIGHT_W-1:0]);
				`TPC_ADDR_TARST: at_rst_reg <= tpc_w_t'(wb_dat_i[WEIGHT_W-1:0]);
				`TPC_ADDR_CLTH: cl_th_reg <= tpc_w_t'(wb_dat_i[WEIGHT_W-1:0]);
				`TPC_ADDR_PITH: pi_th_reg <= tpc_w_t'(wb_dat_i[WEIGHT_W-1:0]);
				`TPC_ADDR_PIRST: pi_rst_reg <= tpc_w_t'(wb_dat_i[WEIGHT_W-1:0]);
				`TPC_ADDR_APTH: ap_th_reg <= tpc_w_t'(wb_dat_i[WEIGHT_W-1:0]);
				`TPC_ADDR_APRST: ap_rst_reg <= tpc_w_t'(wb_dat_i[WEIGHT_W-1:0]);
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_we_i) begin
			unique case (wb_adr_i)
				`TPC_ADDR_CFG: wb_dat_o <= cfg_reg;
				`TPC_ADDR_TATH: wb_dat_o <= 32'(at_th_reg);
				`TPC_ADDR_TARST: wb_dat_o <= 32'(at_rst_reg);
				`TPC_ADDR_CLTH: wb_dat_o <= 32'(cl_th_reg);
				`TPC_ADDR_PITH: wb_dat_o <= 32'(pi_th_reg);
				`TPC_ADDR_PIRST: wb_dat_o <= 32'(pi_rst_reg);
				`TPC_ADDR_APTH: wb_dat_o <= 32'(ap_th_reg);
				`TPC_ADDR_APRST: wb_dat_o <= 32'(ap_rst_reg);
				`TPC_ADDR_STAT: wb_dat_o <= {20'h00000, err_o, printing_o, ap_armed_reg,
					pi_ok_reg, at_wait_reg, at_armed_reg, tare_mem_label_o, net_mode_reg, 1'b0};
				`TPC_ADDR_GROSS: wb_dat_o <= 32'(gross_o);
				`TPC_ADDR_TARE: wb_dat_o <= 32'(tare_o);
				`TPC_ADDR_NET: wb_dat_o <= 32'(net_o);
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Live gross latched per sample for auto tare capture and the outputs; of the thresholds only auto print tests it, the others compare gross_i
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gross_reg <= '0;
		end else if (sample_i) begin
			gross_reg <= gross_i;
		end
	end

	// Auto tare arming, trigger and stability wait
	assign at_fire = cfg_reg[`TPC_CFG_AT_EN] && at_wait_reg && no_motion_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			at_armed_reg <= 1'b1;
			at_wait_reg <= 1'b0;
			at_cnt_reg <= '0;
			at_low_reg <= 1'b0;
		end else begin
			if (sample_i && cfg_reg[`TPC_CFG_AT_EN] && at_armed_reg && gross_i > at_th_reg) begin
				at_armed_reg <= 1'b0;
				at_wait_reg <= 1'b1;
				at_cnt_reg <= '0;
			end else if (at_wait_reg) begin
				if (at_fire || at_cnt_reg >= CNT_W'(WAIT_CYCLES - 1)) begin
					at_wait_reg <= 1'b0;
				end
				at_cnt_reg <= at_cnt_reg + 1'b1;
			end
			if (sample_i) begin
				at_low_reg <= gross_i < at_rst_reg;
			end
			if (!at_armed_reg && !at_wait_reg && at_low_reg) begin
				if (!cfg_reg[`TPC_CFG_AT_MCHK] || no_motion_i) begin
					at_armed_reg <= 1'b1;
				end
			end
		end
	end

	// Auto clear crossing tracker
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cl_above_reg <= 1'b0;
			cl_pend_reg <= 1'b0;
		end else if (!net_mode_reg) begin
			cl_above_reg <= 1'b0;
			cl_pend_reg <= 1'b0;
		end else if (sample_i) begin
			if (gross_i > cl_th_reg) begin
				cl_above_reg <= 1'b1;
				cl_pend_reg <= 1'b0;
			end else if (gross_i < cl_th_reg && cl_above_reg) begin
				cl_above_reg <= 1'b0;
				cl_pend_reg <= 1'b1;
			end
		end else if (auto_clr) begin
			cl_pend_reg <= 1'b0;
		end
	end
	assign auto_clr = cfg_reg[`TPC_CFG_AC_EN] && cl_pend_reg
		&& (!cfg_reg[`TPC_CFG_AC_MCHK] || no_motion_i);

	// Print interlock and auto print arming
	assign pi_block = cfg_reg[`TPC_CFG_PI_EN] && !pi_ok_reg;
	assign print_ok = cfg_reg[`TPC_CFG_DEMPORT];
	assign auto_print = cfg_reg[`TPC_CFG_AP_EN] && ap_armed_reg && no_motion_i
		&& gross_reg > ap_th_reg;
	assign start_demand = print_ok && ((do_print && !pi_block) || auto_print);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pi_ok_reg <= 1'b0;
			pi_done_reg <= 1'b0;
			ap_armed_reg <= 1'b1;
		end else begin
			if (sample_i && gross_i < pi_rst_reg) begin
				pi_ok_reg <= 1'b0;
				pi_done_reg <= 1'b0;
			end else if (sample_i && gross_i > pi_th_reg && !pi_done_reg) begin
				pi_ok_reg <= 1'b1;
			end
			if (start_demand) begin
				pi_ok_reg <= 1'b0;
				pi_done_reg <= 1'b1;
			end
			if (auto_print && print_ok) begin
				ap_armed_reg <= 1'b0;
			end else if (sample_i && gross_i < ap_rst_reg) begin
				ap_armed_reg <= 1'b1;
			end
		end
	end

	// Tare register, net mode and clear sources
	assign clr_any = (do_clear_cmd && net_mode_reg) || auto_clr
		|| (cfg_reg[`TPC_CFG_CWZ] && do_zero)
		|| (sent_reg && print_done_i && (cfg_reg[`TPC_CFG_CAP] || cfg_reg[`TPC_CFG_AC_EN]));
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tare_reg <= '0;
			net_mode_reg <= 1'b0;
		end else if (at_fire) begin
			tare_reg <= gross_reg;
			net_mode_reg <= 1'b1;
		end else if (bus_wr && wb_adr_i == `TPC_ADDR_TAREWR && &wb_sel_i) begin
			tare_reg <= tpc_w_t'(wb_dat_i[WEIGHT_W-1:0]);
			net_mode_reg <= 1'b1;
		end else if (clr_any) begin
			tare_reg <= '0;
			net_mode_reg <= 1'b0;
		end
	end

	// Zero issued one cycle after the tare clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			zero_pend_reg <= 1'b0;
			zero_cmd_o <= 1'b0;
		end else begin
			zero_pend_reg <= do_zero;
			zero_cmd_o <= cfg_reg[`TPC_CFG_CWZ] ? zero_pend_reg : do_zero;
		end
	end

	// Sign correction for every tare source
	always_comb begin
		gross_sel = gross_reg;
		tare_sel = tare_reg;
		if (cfg_reg[`TPC_CFG_NSC] && net_mode_reg && tare_reg > gross_reg) begin
			gross_sel = tare_reg;
			tare_sel = gross_reg;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gross_o <= '0;
			tare_o <= '0;
			net_o <= '0;
			net_mode_o <= 1'b0;
			tare_mem_label_o <= 1'b0;
		end else begin
			gross_o <= gross_sel;
			tare_o <= net_mode_reg ? tare_sel : '0;
			net_o <= net_mode_reg ? tpc_w_t'(gross_sel - tare_sel) : gross_sel;
			net_mode_o <= net_mode_reg;
			tare_mem_label_o <= cfg_reg[`TPC_CFG_NSC] && net_mode_reg;
		end
	end

	// Print requests, printing indication and errors
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			print_o <= '0;
			report_o <= 1'b0;
			pr_cnt_reg <= '0;
			printing_o <= 1'b0;
			sent_reg <= 1'b0;
			err_o <= '0;
		end else begin
			print_o <= '0;
			report_o <= do_report && cfg_reg[`TPC_CFG_RPTPORT];
			if (start_demand) begin
				print_o <= '{valid: 1'b1, kind: TPC_DEMAND, cust_sel: 2'h0,
					dup_mark: 1'b0, count_txn: 1'b1};
			end else if (do_repeat && print_ok) begin
				print_o <= '{valid: 1'b1, kind: TPC_REPEAT, cust_sel: 2'h0,
					dup_mark: 1'b1, count_txn: 1'b0};
			end else if (|do_cust && print_ok) begin
				print_o <= '{valid: 1'b1, kind: TPC_CUSTOM,
					cust_sel: do_cust[0] ? 2'h0 : (do_cust[1] ? 2'h1 : 2'h2),
					dup_mark: 1'b0, count_txn: 1'b0};
			end
			sent_reg <= start_demand || (sent_reg && !print_done_i);
			if (start_demand || (do_repeat && print_ok)) begin
				printing_o <= 1'b1;
				pr_cnt_reg <= '0;
			end else if (printing_o) begin
				pr_cnt_reg <= pr_cnt_reg + 1'b1;
				if (pr_cnt_reg >= CNT_W'(PRINT_CYCLES - 1)) begin
					printing_o <= 1'b0;
				end
			end
			// Flags are sticky; a write to STAT clears, a new event wins
			err_o <= tpc_err_t'(((bus_wr && wb_adr_i == `TPC_ADDR_STAT) ? '0 : err_o)
				| err_set);
		end
	end
	assign err_set = '{no_demand: (do_print || do_repeat || |do_cust) && !print_ok,
		not_ready: do_print && print_ok && pi_block,
		no_report: do_report && !cfg_reg[`TPC_CFG_RPTPORT],
		tare_fail: at_wait_reg && !at_fire && at_cnt_reg >= CNT_W'(WAIT_CYCLES - 1)};

	interlock_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
		do_print && print_ok && pi_block |=> err_o.not_ready)
		else $error("blocked print did not flag not ready");
	nodemand_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
		do_print && !print_ok |=> err_o.no_demand && !print_o.valid)
		else $error("print without demand port not failed");
	sequence at_fire_s;
		at_fire && !clr_any;
	endsequence
	auto_tare_a: assert property (@(posedge clk_i) disable iff (rst_i)
		at_fire_s |=> net_mode_reg && tare_reg == $past(gross_reg))
		else $error("auto tare did not store weight");
	manual_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		do_clear_cmd && net_mode_reg && !at_fire |=> !net_mode_reg && tare_reg == '0)
		else $error("manual clear ignored");
	sign_corr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_reg[`TPC_CFG_NSC] && net_mode_reg |=> net_o >= 0)
		else $error("corrected net negative");
	nocorr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!cfg_reg[`TPC_CFG_NSC] && net_mode_reg |=> tare_o == $past(tare_reg))
		else $error("tare swapped with correction off");
	printing_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
		start_demand |=> printing_o [*2])
		else $error("printing indication missing");
	repeat_dup_a: assert property (@(posedge clk_i) disable iff (rst_i)
		do_repeat && print_ok && !start_demand |=> print_o.dup_mark && !print_o.count_txn)
		else $error("repeat not marked duplicate");
	zero_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_reg[`TPC_CFG_CWZ] && do_zero && $stable(cfg_reg) |=> !net_mode_reg ##1 zero_cmd_o)
		else $error("zero before tare clear");
	mem_label_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_reg[`TPC_CFG_NSC] && net_mode_reg |=> tare_mem_label_o)
		else $error("memory label missing");
endmodule

// ---- rtl/tpc_consts.svh ----
// Register map, field positions, reset values and timing counts for tare and print control
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH
`define TPC_ADDR_CFG 8'h00
`define TPC_ADDR_TATH 8'h04
`define TPC_ADDR_TARST 8'h08
`define TPC_ADDR_CLTH 8'h0C
`define TPC_ADDR_PITH 8'h10
`define TPC_ADDR_PIRST 8'h14
`define TPC_ADDR_APTH 8'h18
`define TPC_ADDR_APRST 8'h1C
`define TPC_ADDR_CMD 8'h20
`define TPC_ADDR_STAT 8'h24
`define TPC_ADDR_GROSS 8'h28
`define TPC_ADDR_TARE 8'h2C
`define TPC_ADDR_NET 8'h30
`define TPC_ADDR_TAREWR 8'h34
`define TPC_CFG_NSC 0
`define TPC_CFG_AT_EN 1
`define TPC_CFG_AT_MCHK 2
`define TPC_CFG_AC_EN 3
`define TPC_CFG_AC_MCHK 4
`define TPC_CFG_CAP 5
`define TPC_CFG_CWZ 6
`define TPC_CFG_PI_EN 7
`define TPC_CFG_AP_EN 8
`define TPC_CFG_DEMPORT 9
`define TPC_CFG_RPTPORT 10
`define TPC_CMD_CLEAR 0
`define TPC_CMD_ZERO 1
`define TPC_CMD_PRINT 2
`define TPC_CMD_REPEAT 3
`define TPC_CMD_CUST0 4
`define TPC_CMD_REPORT 7
`define TPC_CFG_RST 32'h0000_0000
`define TPC_WAIT_MS 3000
`define TPC_PRINT_MS 3000
`define TPC_TICK_NS 1000000
`define TPC_CLK_NS 20
`endif

// ---- rtl/tpc_pkg.sv ----
// Types shared by the tare and print control block
package tpc_pkg;
	typedef enum logic [2:0] {
		TPC_DEMAND = 3'h1,
		TPC_REPEAT = 3'h2,
		TPC_CUSTOM = 3'h4
	} tpc_kind_t;
	typedef struct packed {
		logic valid;
		tpc_kind_t kind;
		logic [1:0] cust_sel;
		logic dup_mark;
		logic count_txn;
	} tpc_print_t;
	typedef struct packed {
		logic no_demand;
		logic not_ready;
		logic no_report;
		logic tare_fail;
	} tpc_err_t;
endpackage

// ---- tb/tpc_scale_model.sv ----
// Weigh scale front end and output port model for the tare and print bench
`timescale 1ns/1ps
module tpc_scale_model import tpc_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic signed [23:0] load_i,
	input wire logic still_i,
	input wire tpc_print_t print_i,
	output logic sample_o,
	output logic signed [23:0] gross_o,
	output logic no_motion_o,
	output logic print_done_o
);
	logic [1:0] div_reg;
	logic [2:0] busy_reg;
	// Weight is only valid with the strobe, so the line is scrambled in between
	always_ff @(posedge clk_i) begin
		div_reg <= rst_i ? 2'h0 : div_reg + 2'h1;
		sample_o <= !rst_i && div_reg == 2'h3;
		gross_o <= (div_reg == 2'h3) ? load_i : ~load_i;
		no_motion_o <= still_i;
	end
	// Port takes a few cycles to push out the record before it reports done
	always_ff @(posedge clk_i) begin
		busy_reg <= rst_i ? 3'h0 : {busy_reg[1:0], print_i.valid};
		print_done_o <= busy_reg[2];
	end
endmodule

// ---- tb/tare_and_print_control_test.sv ----
// Register level bench for the tare and print control block
`timescale 1ns/1ps
`include "tpc_consts.svh"
module tare_and_print_control_test import tpc_pkg::*;;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc, wb_stb, wb_we, wb_ack_o;
	logic [7:0] wb_adr;
	logic [31:0] wb_dat, wb_dat_o, q;
	logic sample, no_motion, print_done, still;
	logic signed [23:0] gross_in, load, gross_o, tare_o, net_o;
	logic net_mode_o, label_o, zero_cmd_o, report_o, printing_o, rp;
	tpc_print_t print_o, pr;
	tpc_err_t err_o;
	int err_count, comparisons, prints, zeros, p0;

	always #10 clk_i = ~clk_i;

	tpc_ctrl #(.WEIGHT_W(24), .WAIT_CYCLES(20), .PRINT_CYCLES(20)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_i(sample), .gross_i(gross_in),
		.no_motion_i(no_motion), .print_done_i(print_done), .gross_o(gross_o),
		.tare_o(tare_o), .net_o(net_o), .net_mode_o(net_mode_o),
		.tare_mem_label_o(label_o), .zero_cmd_o(zero_cmd_o), .print_o(print_o),
		.report_o(report_o), .printing_o(printing_o), .err_o(err_o));

	tpc_scale_model scale (.clk_i(clk_i), .rst_i(rst_i), .load_i(load), .still_i(still),
		.print_i(print_o), .sample_o(sample), .gross_o(gross_in),
		.no_motion_o(no_motion), .print_done_o(print_done));

	task end_of_test;
		if (err_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task chk(input logic [23:0] g, input logic [23:0] e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t value %h expected %h", $time, g, e);
		end
	endtask

	task chb(input logic g, input logic e);
		chk({23'h0, g}, {23'h0, e});
	endtask

	// One classic cycle; the answer is taken at the edge that shows ack high
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		chb(n < 50, 1'b1);
		q = wb_dat_o;
		pr = print_o;
		rp = report_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask

	task cmd(input int b);
		wb(1'b1, `TPC_ADDR_CMD, 32'h1 << b);
	endtask

	// Status write also clears the sticky errors left by the previous case
	task cfg(input logic [31:0] v);
		wb(1'b1, `TPC_ADDR_CFG, v);
		wb(1'b1, `TPC_ADDR_STAT, 32'h0);
	endtask

	task settle(input logic signed [23:0] w, input logic s);
		load <= w;
		still <= s;
		repeat (12) @(posedge clk_i);
	endtask

	always @(posedge clk_i) begin
		if (print_o.valid === 1'b1) prints++;
		if (zero_cmd_o === 1'b1) begin
			zeros++;
			chk(tare_o, 24'h0);
		end
	end

	initial begin
		#(20 * 4000);
		err_count++;
		$display("BAD %0t watchdog expired", $time);
		end_of_test;
	end

	initial begin
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
		load = 24'sd0;
		still = 1'b1;
		{err_count, comparisons, prints, zeros} = '0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(tare_o, 24'h0);
		wb(1'b0, `TPC_ADDR_CFG, 32'h0);
		chk(q[23:0], 24'h0);
		wb(1'b0, 8'hFC, 32'h0);
		chk(q[23:0], 24'h0);
		settle(16, 1);
		wb(1'b1, `TPC_ADDR_TAREWR, 32'd53);
		settle(16, 1);
		chk(gross_o, 24'sd16);
		chk(tare_o, 24'sd53);
		chk(net_o, -24'sd37);
		chb(label_o, 1'b0);
		cfg(32'h1);
		settle(16, 1);
		chk(gross_o, 24'sd53);
		chk(tare_o, 24'sd16);
		chk(net_o, 24'sd37);
		chb(label_o, 1'b1);
		cfg(32'h0);
		settle(16, 0);
		cmd(`TPC_CMD_CLEAR);
		settle(16, 0);
		chb(net_mode_o || tare_o !== 0, 1'b0);
		cmd(`TPC_CMD_PRINT);
		chb(err_o.no_demand && !pr.valid, 1'b1);
		// Demand port plus clear after print
		cfg(32'h220);
		wb(1'b1, `TPC_ADDR_TAREWR, 32'd10);
		settle(16, 1);
		cmd(`TPC_CMD_PRINT);
		chb(pr.valid && pr.kind === TPC_DEMAND && pr.count_txn, 1'b1);
		repeat (4) @(posedge clk_i);
		chb(printing_o && !err_o.no_demand, 1'b1);
		repeat (20) @(posedge clk_i);
		chb(printing_o, 1'b0);
		chb(net_mode_o, 1'b0);
		cmd(`TPC_CMD_REPEAT);
		chb(pr.valid && pr.kind === TPC_REPEAT && pr.dup_mark, 1'b1);
		for (int i = 0; i < 3; i++) begin
			cmd(`TPC_CMD_CUST0 + i);
			chb(pr.valid && pr.kind === TPC_CUSTOM && pr.cust_sel === i[1:0], 1'b1);
			chb(pr.count_txn, 1'b0);
		end
		// Report needs its own port; without one it is refused with an error
		cmd(`TPC_CMD_REPORT);
		chb(rp || !err_o.no_report, 1'b0);
		cfg(32'h620);
		cmd(`TPC_CMD_REPORT);
		chb(rp && !err_o.no_report, 1'b1);
		cfg(32'h40);
		wb(1'b1, `TPC_ADDR_TAREWR, 32'd10);
		settle(16, 1);
		cmd(`TPC_CMD_ZERO);
		settle(16, 1);
		chb(zeros == 1 && !net_mode_o, 1'b1);
		cfg(32'h280);
		wb(1'b1, `TPC_ADDR_PITH, 32'd100);
		wb(1'b1, `TPC_ADDR_PIRST, 32'd50);
		settle(20, 1);
		cmd(`TPC_CMD_PRINT);
		chb(!pr.valid && err_o.not_ready, 1'b1);
		settle(150, 1);
		cmd(`TPC_CMD_PRINT);
		chb(pr.valid, 1'b1);
		settle(150, 1);
		settle(150, 1);
		cmd(`TPC_CMD_PRINT);
		chb(pr.valid, 1'b0);
		cfg(32'h2);
		wb(1'b1, `TPC_ADDR_TATH, 32'd100);
		wb(1'b1, `TPC_ADDR_TARST, 32'd50);
		settle(20, 1);
		// Drop the tare taken while the trigger threshold was still zero
		cmd(`TPC_CMD_CLEAR);
		settle(150, 1);
		chb(net_mode_o && tare_o === 24'sd150 && net_o === 24'sd0, 1'b1);
		cmd(`TPC_CMD_CLEAR);
		settle(150, 1);
		chb(net_mode_o, 1'b0);
		settle(20, 0);
		settle(150, 1);
		chb(net_mode_o, 1'b1);
		cfg(32'h6);
		cmd(`TPC_CMD_CLEAR);
		settle(20, 0);
		settle(150, 0);
		settle(150, 1);
		chb(net_mode_o, 1'b0);
		settle(20, 1);
		settle(150, 0);
		settle(150, 1);
		chb(net_mode_o, 1'b1);
		cmd(`TPC_CMD_CLEAR);
		settle(20, 1);
		settle(150, 0);
		settle(150, 0);
		settle(150, 0);
		chb(err_o.tare_fail && !net_mode_o, 1'b1);
		cfg(32'h300);
		wb(1'b1, `TPC_ADDR_APTH, 32'd100);
		wb(1'b1, `TPC_ADDR_APRST, 32'd50);
		settle(20, 1);
		p0 = prints;
		settle(150, 1);
		settle(150, 1);
		settle(150, 1);
		chb(prints == p0 + 1, 1'b1);
		settle(20, 1);
		settle(150, 1);
		chb(prints == p0 + 2, 1'b1);
		cfg(32'h8);
		wb(1'b1, `TPC_ADDR_CLTH, 32'd100);
		settle(150, 1);
		wb(1'b1, `TPC_ADDR_TAREWR, 32'd10);
		settle(150, 1);
		settle(20, 0);
		chb(net_mode_o, 1'b0);
		cfg(32'h18);
		settle(150, 1);
		wb(1'b1, `TPC_ADDR_TAREWR, 32'd10);
		settle(150, 0);
		settle(20, 0);
		chb(net_mode_o, 1'b1);
		settle(20, 1);
		chb(net_mode_o, 1'b0);
		end_of_test;
	end
endmodule
